// ### acs_decim.sv
// Decimation filter: counts ones of the modulator bitstream over one conversion.
// Assumes mod_valid_i strobes once per modulator cycle, start_i opens a window.
`timescale 1ns/1ns
`include "acs_map.svh"
module acs_decim #(
  parameter int CODE_W = `ACS_CODE_W,
  parameter int CNT_W  = 16
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              start_i,
  input  wire logic              finish_i,
  input  wire logic              mod_valid_i,
  input  wire logic              mod_bit_i,
  input  wire logic [CNT_W-1:0]  len_i,
  output logic      [CODE_W-1:0] code_o
);
  typedef struct packed {
    logic [CNT_W-1:0]  ones;
    logic [CODE_W-1:0] code;
  } acs_decim_st_t;

  acs_decim_st_t s_q;
  acs_decim_st_t s_d;
  logic [CNT_W+CODE_W-1:0] scaled;
  logic [CNT_W+CODE_W-1:0] signed_code;

  initial begin
    if (CNT_W < 8 || CODE_W < 2) begin
      $error("acs_decim: width too small");
    end
  end

  always_comb begin
    s_d = s_q;
    // Ones density scaled to code range, then offset to two's complement
    scaled      = ({{CODE_W{1'b0}}, s_q.ones} << CODE_W) / {{CODE_W{1'b0}}, len_i};
    signed_code = scaled - ({{(CNT_W+CODE_W-1){1'b0}}, 1'b1} << (CODE_W - 1));
    if (start_i) begin
      s_d.ones = '0;
    end else if (mod_valid_i && mod_bit_i) begin
      s_d.ones = s_q.ones + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    if (finish_i) begin
      s_d.code = (scaled >= ({{(CNT_W+CODE_W-1){1'b0}}, 1'b1} << CODE_W)) ?
                 {1'b0, {(CODE_W-1){1'b1}}} : signed_code[CODE_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign code_o = s_q.code;
endmodule : acs_decim

// ### acs_map.svh
// Constants for the conversion sequencer: mux codes, rate codes, timing counts.
// Assumes a 100 MHz system clock standing in for the internal oscillator domain.
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

`define ACS_CLK_PERIOD_NS      10
`define ACS_OSC_PERIOD_NS      1000
`define ACS_OSC_DIV_CYC        (`ACS_OSC_PERIOD_NS / `ACS_CLK_PERIOD_NS)
`define ACS_MOD_DIV            4
`define ACS_MOD_PHASES         4
`define ACS_CODE_W             12
`define ACS_SEL_W              3
`define ACS_RATE_W             3
`define ACS_NUM_RATES          7
`define ACS_MOD_HZ             250000

`define ACS_SEL_D01            3'h0
`define ACS_SEL_D03            3'h1
`define ACS_SEL_D13            3'h2
`define ACS_SEL_D23            3'h3
`define ACS_SEL_S0             3'h4
`define ACS_SEL_S1             3'h5
`define ACS_SEL_S2             3'h6
`define ACS_SEL_S3             3'h7

`define ACS_SEL_RST            3'h0
`define ACS_RATE_RST           3'h4

`define ACS_SPS_0              128
`define ACS_SPS_1              250
`define ACS_SPS_2              490
`define ACS_SPS_3              920
`define ACS_SPS_4              1600
`define ACS_SPS_5              2400
`define ACS_SPS_6              3300

`define ACS_RESULT_RST         12'h000

`endif

// ### acs_mod_model.sv
// Modulator bitstream source on the far side of the bit input.
// Assumes a new bit is due at each rise of the modulator clock.
`timescale 1ns/1ns
module acs_mod_model (
  input  wire logic       mod_clk_i,
  input  wire logic [7:0] density_i,
  output logic            mod_bit_o
);
  logic [8:0] acc_q = 9'h0;
  // First-order accumulator: ones density is density_i / 256
  always @(posedge mod_clk_i) begin
    acc_q <= {1'b0, acc_q[7:0]} + {1'b0, density_i};
  end
  assign mod_bit_o = acc_q[8];
endmodule : acs_mod_model

// ### acs_pkg.sv
// Types for the conversion sequencer.
// Assumes acs_map.svh for all numeric constants.
`include "acs_map.svh"
package acs_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_DONE
  } acs_state_t;

  typedef struct packed {
    logic [3:0] pos_sel;
    logic [3:0] neg_sel;
    logic       neg_gnd;
  } acs_route_t;

  typedef struct packed {
    logic sample;
    logic discharge;
  } acs_sw_t;

endpackage : acs_pkg

// ### acs_seq.sv
// Conversion sequencer top: mode control, input routing, modulator phasing, result.
// Assumes the modulator bit is a pin input; mode and config come from the
// serial-bus register logic on the same clock.
`timescale 1ns/1ns
`include "acs_map.svh"
module acs_seq #(
  parameter bit HAS_MUX = 1'b1,
  parameter int CNT_W   = 16
) (
  input  wire logic                      MCLK_I,
  input  wire logic                      RSTN_I,
  input  wire logic                      CONT_MODE_I,
  input  wire logic                      START_REQ_I,
  input  wire logic [`ACS_SEL_W-1:0]     INPUT_SELECT_FIELD_I,
  input  wire logic [`ACS_RATE_W-1:0]    RATE_SELECT_FIELD_I,
  input  wire logic                      MOD_BIT_I,
  output logic      [`ACS_CODE_W-1:0]    RESULT_O,
  output logic                           RESULT_VALID_O,
  output logic                           BUSY_O,
  output logic                           POWER_DOWN_O,
  output logic                           MOD_CLK_O,
  output logic                           SAMPLING_SWITCH_O,
  output logic                           DISCHARGE_SWITCH_O,
  output logic      [3:0]                POS_CONVERTER_INPUT_O,
  output logic      [3:0]                NEG_CONVERTER_INPUT_O,
  output logic                           NEG_GND_SWITCH_O
);
  localparam int OSC_W = 8;
  localparam int NR    = `ACS_NUM_RATES;

  typedef struct packed {
    acs_pkg::acs_state_t       state;
    logic [OSC_W-1:0]          osc_cnt;
    logic [1:0]                mod_ph;
    logic [CNT_W-1:0]          mod_cnt;
    logic [CNT_W-1:0]          conv_len;
    logic [`ACS_CODE_W-1:0]    result;
    logic                      res_valid;
    logic                      done_pls;
    acs_pkg::acs_route_t       route;
    acs_pkg::acs_sw_t          sw;
    logic                      mod_clk;
    logic                      bit_s1;
    logic                      bit_s2;
    logic                      busy;
    logic                      pdown;
  } acs_seq_st_t;

  acs_seq_st_t s_q;
  acs_seq_st_t s_d;

  logic                   osc_tick;
  logic                   mod_tick;
  logic                   conv_start;
  logic                   conv_end;
  logic [CNT_W-1:0]       rate_len;
  logic [`ACS_CODE_W-1:0] dec_code;
  logic [CNT_W-1:0]       len_tab [NR];
  acs_pkg::acs_route_t    route_sel;

  // Modulator cycles per conversion for each rate code
  genvar gi;
  generate
    for (gi = 0; gi < NR; gi++) begin : g_rate
      localparam int SPS = (gi == 0) ? `ACS_SPS_0 : (gi == 1) ? `ACS_SPS_1 :
                           (gi == 2) ? `ACS_SPS_2 : (gi == 3) ? `ACS_SPS_3 :
                           (gi == 4) ? `ACS_SPS_4 : (gi == 5) ? `ACS_SPS_5 : `ACS_SPS_6;
      assign len_tab[gi] = CNT_W'(`ACS_MOD_HZ / SPS);
    end
  endgenerate

  initial begin
    if (CNT_W < 12 || (`ACS_MOD_HZ / `ACS_SPS_0) >= (1 << CNT_W)) begin
      $error("acs_seq: CNT_W cannot hold the longest conversion");
    end
  end

  always_comb begin
    // Code 7 is unused by the seven rates; it falls back to the fastest
    if (RATE_SELECT_FIELD_I == 3'h7) begin
      rate_len = len_tab[NR-1];
    end else begin
      rate_len = len_tab[RATE_SELECT_FIELD_I];
    end
  end

  always_comb begin
    route_sel.pos_sel = 4'h1;
    route_sel.neg_sel = 4'h2;
    route_sel.neg_gnd = 1'b0;
    if (HAS_MUX) begin
      case (INPUT_SELECT_FIELD_I)
        `ACS_SEL_D01: begin
          route_sel.pos_sel = 4'h1;
          route_sel.neg_sel = 4'h2;
        end
        `ACS_SEL_D03: begin
          route_sel.pos_sel = 4'h1;
          route_sel.neg_sel = 4'h8;
        end
        `ACS_SEL_D13: begin
          route_sel.pos_sel = 4'h2;
          route_sel.neg_sel = 4'h8;
        end
        `ACS_SEL_D23: begin
          route_sel.pos_sel = 4'h4;
          route_sel.neg_sel = 4'h8;
        end
        `ACS_SEL_S0, `ACS_SEL_S1, `ACS_SEL_S2, `ACS_SEL_S3: begin
          route_sel.pos_sel = 4'h1 << INPUT_SELECT_FIELD_I[1:0];
          route_sel.neg_sel = 4'h0;
          route_sel.neg_gnd = 1'b1;
        end
        default: begin
          route_sel.pos_sel = 4'h1;
          route_sel.neg_sel = 4'h2;
        end
      endcase
    end
  end

  assign osc_tick   = (s_q.osc_cnt == OSC_W'(`ACS_OSC_DIV_CYC - 1));
  assign mod_tick   = osc_tick && (s_q.mod_ph == 2'(`ACS_MOD_DIV - 1));
  assign conv_end   = (s_q.state == acs_pkg::ST_CONV) && mod_tick &&
                      (s_q.mod_cnt == s_q.conv_len - {{(CNT_W-1){1'b0}}, 1'b1});
  // Request accepted only from idle; a busy core ignores it
  assign conv_start = (s_q.state == acs_pkg::ST_IDLE) && START_REQ_I && !CONT_MODE_I;

  always_comb begin
    s_d          = s_q;
    s_d.bit_s1   = MOD_BIT_I;
    s_d.bit_s2   = s_q.bit_s1;
    s_d.done_pls = 1'b0;
    s_d.osc_cnt  = osc_tick ? '0 : s_q.osc_cnt + {{(OSC_W-1){1'b0}}, 1'b1};
    if (osc_tick) begin
      s_d.mod_ph = s_q.mod_ph + 2'h1;
    end
    s_d.mod_clk = (s_d.mod_ph < 2'h2);
    if (s_q.state == acs_pkg::ST_CONV) begin
      // Phase 0-1 sample, phase 2 break-before-make gap, phase 3 discharge
      s_d.sw.sample    = (s_d.mod_ph < 2'h2);
      s_d.sw.discharge = (s_d.mod_ph == 2'h3);
    end else begin
      s_d.sw = '0;
    end
    case (s_q.state)
      acs_pkg::ST_IDLE: begin
        if (conv_start || CONT_MODE_I) begin
          s_d.state    = acs_pkg::ST_CONV;
          // First tick aligns to the free-running modulator and the decimator counts its bit; it wraps the count to zero
          s_d.mod_cnt  = '1;
          s_d.conv_len = rate_len;
          s_d.route    = route_sel;
        end
      end
      acs_pkg::ST_CONV: begin
        if (mod_tick) begin
          s_d.mod_cnt = s_q.mod_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        if (conv_end) begin
          s_d.state = acs_pkg::ST_DONE;
        end
      end
      acs_pkg::ST_DONE: begin
        s_d.result    = dec_code;
        s_d.res_valid = 1'b1;
        s_d.done_pls  = 1'b1;
        s_d.mod_cnt   = '0;
        if (CONT_MODE_I) begin
          // Next conversion restarts at once, keeping the 1/rate cadence
          s_d.state    = acs_pkg::ST_CONV;
          s_d.conv_len = rate_len;
          s_d.route    = route_sel;
        end else begin
          s_d.state = acs_pkg::ST_IDLE;
        end
      end
      default: begin
        s_d.state = acs_pkg::ST_IDLE;
      end
    endcase
    s_d.busy  = (s_d.state != acs_pkg::ST_IDLE);
    s_d.pdown = (s_d.state == acs_pkg::ST_IDLE);
  end

  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      s_q          <= '0;
      s_q.state    <= acs_pkg::ST_IDLE;
      s_q.result   <= `ACS_RESULT_RST;
      s_q.route    <= '{pos_sel: 4'h1, neg_sel: 4'h2, neg_gnd: 1'b0};
      s_q.mod_clk  <= 1'b1;
      s_q.pdown    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  acs_decim #(
    .CODE_W (`ACS_CODE_W),
    .CNT_W  (CNT_W)
  ) u_decim (
    .clk_i       (MCLK_I),
    .rst_n_i     (RSTN_I),
    .start_i     (s_q.state != acs_pkg::ST_CONV),
    .finish_i    (conv_end),
    .mod_valid_i (mod_tick && (s_q.state == acs_pkg::ST_CONV)),
    .mod_bit_i   (s_q.bit_s2),
    .len_i       (s_q.conv_len),
    .code_o      (dec_code)
  );

  assign RESULT_O              = s_q.result;
  assign RESULT_VALID_O        = s_q.done_pls;
  assign BUSY_O                = s_q.busy;
  assign POWER_DOWN_O          = s_q.pdown;
  assign MOD_CLK_O             = s_q.mod_clk;
  assign SAMPLING_SWITCH_O     = s_q.sw.sample;
  assign DISCHARGE_SWITCH_O    = s_q.sw.discharge;
  assign POS_CONVERTER_INPUT_O = s_q.route.pos_sel;
  assign NEG_CONVERTER_INPUT_O = s_q.route.neg_sel;
  assign NEG_GND_SWITCH_O      = s_q.route.neg_gnd;
endmodule : acs_seq

// ### acs_seq_properties.sv
// Port checker for the conversion sequencer.
// Assumes a bind onto acs_seq with the mux fitted and one clock.
`timescale 1ns/1ns
module acs_seq_properties (
  input wire logic       MCLK_I,
  input wire logic       RSTN_I,
  input wire logic       CONT_MODE_I,
  input wire logic [2:0] INPUT_SELECT_FIELD_I,
  input wire logic [2:0] RATE_SELECT_FIELD_I,
  input wire logic [11:0] RESULT_O,
  input wire logic       RESULT_VALID_O,
  input wire logic       BUSY_O,
  input wire logic       POWER_DOWN_O,
  input wire logic       MOD_CLK_O,
  input wire logic       SAMPLING_SWITCH_O,
  input wire logic       DISCHARGE_SWITCH_O,
  input wire logic [3:0] POS_CONVERTER_INPUT_O,
  input wire logic [3:0] NEG_CONVERTER_INPUT_O,
  input wire logic       NEG_GND_SWITCH_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);

  logic        mprev_q, mseen_q, vseen_q;
  logic [31:0] mcnt_q, vcnt_q;
  wire         mrise = MOD_CLK_O && !mprev_q;
  wire         mfall = !MOD_CLK_O && mprev_q;

  function automatic logic [8:0] route(input logic [2:0] s);
    case (s)
      3'h0:    route = {4'h1, 4'h2, 1'b0};
      3'h1:    route = {4'h1, 4'h8, 1'b0};
      3'h2:    route = {4'h2, 4'h8, 1'b0};
      3'h3:    route = {4'h4, 4'h8, 1'b0};
      default: route = {4'h1 << s[1:0], 4'h0, 1'b1};
    endcase
  endfunction : route

  // Cycles since the last modulator rise and since the last result
  always_ff @(posedge MCLK_I) begin
    mprev_q <= MOD_CLK_O;
    mcnt_q  <= mrise ? 32'h1 : mcnt_q + 32'h1;
    vcnt_q  <= RESULT_VALID_O ? 32'h1 : vcnt_q + 32'h1;
    if (!RSTN_I) begin
      mseen_q <= 1'b0;
      vseen_q <= 1'b0;
    end else begin
      mseen_q <= mseen_q | mrise;
      vseen_q <= CONT_MODE_I & (vseen_q | RESULT_VALID_O);
    end
  end

  a_route_on_start: assert property ($rose(BUSY_O) |->
    {POS_CONVERTER_INPUT_O, NEG_CONVERTER_INPUT_O, NEG_GND_SWITCH_O}
    == route($past(INPUT_SELECT_FIELD_I))) else $error("routing differs from select");
  a_gnd_neg_off: assert property (NEG_GND_SWITCH_O |-> NEG_CONVERTER_INPUT_O == 4'h0)
    else $error("negative input not released when grounded");
  a_mod_period: assert property (mrise && mseen_q |-> mcnt_q == 32'h190)
    else $error("modulator clock period wrong");
  a_mod_high: assert property (mfall && mseen_q |-> mcnt_q == 32'hc8)
    else $error("modulator clock high time wrong");
  a_switch_excl: assert property (!(SAMPLING_SWITCH_O && DISCHARGE_SWITCH_O))
    else $error("both switch sets closed");
  a_discharge_gap: assert property ($fell(SAMPLING_SWITCH_O) |-> !DISCHARGE_SWITCH_O [*8])
    else $error("discharge closed without gap");
  a_single_idle: assert property (RESULT_VALID_O && !CONT_MODE_I |-> POWER_DOWN_O && !BUSY_O)
    else $error("no power-down after single result");
  a_cont_restart: assert property (RESULT_VALID_O && CONT_MODE_I |-> BUSY_O)
    else $error("continuous mode did not restart");
  a_cont_cadence: assert property (RESULT_VALID_O && vseen_q && RATE_SELECT_FIELD_I == 3'h6
    |-> vcnt_q inside {[32'h752c:32'h7534]}) else $error("continuous cadence wrong");
  a_valid_pulse: assert property (RESULT_VALID_O |=> !RESULT_VALID_O)
    else $error("result strobe longer than one cycle");
  a_result_hold: assert property ($changed(RESULT_O) |-> RESULT_VALID_O)
    else $error("result changed without strobe");
endmodule : acs_seq_properties

// ### tb.sv
// Self-checking bench for the conversion sequencer.
// Assumes acs_seq, its checker and the modulator model alongside.
`timescale 1ns/1ns
module tb;
  logic        clk = 1'b0, rst_n = 1'b0, cont = 1'b0, start = 1'b0;
  logic [2:0]  sel = 3'h0, rate = 3'h6;
  logic [7:0]  density = 8'h0;
  logic        mod_bit, valid, busy, pdown, mclk, s_sw, d_sw, gnd;
  logic [11:0] result;
  logic [3:0]  pos, neg;
  int          failures = 0, checked = 0, seed = 32'h292b;
  bit          exp_q[$];
  time         t0;

  acs_seq u_acs_seq (.MCLK_I(clk), .RSTN_I(rst_n), .CONT_MODE_I(cont), .START_REQ_I(start),
    .INPUT_SELECT_FIELD_I(sel), .RATE_SELECT_FIELD_I(rate), .MOD_BIT_I(mod_bit),
    .RESULT_O(result), .RESULT_VALID_O(valid), .BUSY_O(busy), .POWER_DOWN_O(pdown),
    .MOD_CLK_O(mclk), .SAMPLING_SWITCH_O(s_sw), .DISCHARGE_SWITCH_O(d_sw),
    .POS_CONVERTER_INPUT_O(pos), .NEG_CONVERTER_INPUT_O(neg), .NEG_GND_SWITCH_O(gnd));
  acs_mod_model u_acs_mod_model (.mod_clk_i(mclk), .density_i(density), .mod_bit_o(mod_bit));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic check(input bit ok, input string msg);
    checked++;
    if (!ok) begin
      failures++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic do_reset();
    rst_n <= 1'b0;
    cyc(5);
    rst_n <= 1'b1;
    cyc(1);
  endtask : do_reset

  task automatic wait_valid(input int lim);
    repeat (lim) begin
      @(posedge clk);
      if (valid === 1'b1) return;
    end
    check(1'b0, "no result");
  endtask : wait_valid

  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // Each result takes the oldest expected sign off the queue
  always @(posedge clk) begin
    if (valid === 1'b1) begin
      if (exp_q.size() == 0) check(1'b0, "unexpected result");
      else if (exp_q.pop_front()) check(result[11] === 1'b0 && result !== 12'h0, "sign");
      else check(result[11] === 1'b1, "sign");
    end
  end

  initial begin
    do_reset();
    // Every select code, aborted by reset right after the start
    for (int c = 0; c < 8; c++) begin
      sel   <= c[2:0];
      start <= 1'b1;
      cyc(1);
      start <= 1'b0;
      cyc(3);
      check(gnd === (c > 3), "ground switch");
      check(busy === 1'b1 && pdown === 1'b0, "start not taken");
      do_reset();
    end
    // Single shot at rate code 7 with request noise while busy
    density <= 8'hff;
    rate    <= 3'h7;
    start   <= 1'b1;
    exp_q.push_back(1'b1);
    cyc(1);
    t0 = $time;
    repeat (1000) begin
      start <= 1'($random(seed));
      cyc(1);
    end
    start <= 1'b0;
    wait_valid(31000);
    check(($time - t0) / 10 inside {[30000:30410]}, "conversion time");
    cyc(500);
    check(pdown === 1'b1 && busy === 1'b0, "not idle after result");
    // Continuous at 3300 per second, two results
    density <= 8'h0;
    rate    <= 3'h6;
    cont    <= 1'b1;
    exp_q.push_back(1'b0);
    exp_q.push_back(1'b0);
    wait_valid(30500);
    wait_valid(30100);
    do_reset();
    check(exp_q.size() == 0, "results missing");
    print_verdict();
  end

  initial begin
    #990000;
    failures++;
    print_verdict();
  end
endmodule : tb

bind acs_seq acs_seq_properties u_acs_seq_properties (.*);
